// File: verilog/rfs_regs.svh
// Purpose: offsets, fields, reset values and timing counts of the fault
//          supervisor
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes:   definitions only
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

`define RFS_ADDR_W          4
`define RFS_OFF_STATUS      4'h0
`define RFS_OFF_IRQ_CLR     4'h4
`define RFS_OFF_IRQ_EN      4'h8
`define RFS_OFF_CTRL        4'hC

`define RFS_EVT_W           6
`define RFS_EVT_HICCUP      0
`define RFS_EVT_DIODE       1
`define RFS_EVT_SWSHORT     2
`define RFS_EVT_PREOV       3
`define RFS_EVT_PUMP        4
`define RFS_EVT_LOWUV       5

`define RFS_CTRL_W          8
`define RFS_CTRL_RESET      8'h00
`define RFS_CNT_W           6
`define RFS_OC_LIMIT_LOW    6'h0F
`define RFS_OC_LIMIT_HIGH   6'h3C
`define RFS_CNT_ZERO        6'h00
`define RFS_CNT_ONE         6'h01

// default oscillator frequency and the divider from the 40 MHz clock
`define RFS_CLK_HZ          40000000
`define RFS_DEF_OSC_HZ      900000
`define RFS_DIV_W           6
`define RFS_DIV_ONE         6'h01
`define RFS_DIV_ZERO        6'h00

// hiccup off time, in switching cycles
`define RFS_HICCUP_CYC_W    8
`define RFS_HICCUP_CYC      8'h40
`define RFS_HCC_ZERO        8'h00
`define RFS_HCC_ONE         8'h01

`define RFS_WORD_ZERO       32'h0000_0000

`endif

// File: verilog/rfs_pkg.sv
// Purpose: shared types of the fault supervisor
// Assumes: nothing
// Notes:   constants live in rfs_regs.svh
package rfs_pkg;

	typedef enum logic [1:0] {
		RFS_RUN,
		RFS_HICCUP,
		RFS_LATCHED
	} rfs_state_e;

endpackage : rfs_pkg

// File: verilog/rfs_event_sync.sv
// Purpose: sticky event status with enable and write-one clear
// Assumes: one clock, synchronous reset
// Notes:   a set wins over a clear in the same cycle
`timescale 1ns/1ps

module rfs_event_sync #(
	parameter int W = 6
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// event pulses
	input  wire logic [W-1:0] evt_pulse,
	// software side
	input  wire logic [W-1:0] clr_bits,
	input  wire logic         clr_we,
	input  wire logic [W-1:0] en_bits,
	// results
	output logic      [W-1:0] status,
	output logic              irq
);

	logic [W-1:0] status_ff;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge mclk)
			begin
				if (sys_rst)
					status_ff[i] <= 1'b0;
				else if (evt_pulse[i])
					status_ff[i] <= 1'b1;
				else if (clr_we && clr_bits[i])
					status_ff[i] <= 1'b0;
			end
		end
	endgenerate

	assign status = status_ff;
	assign irq    = |(status_ff & en_bits);

endmodule : rfs_event_sync

// File: verilog/rfs_supervisor.sv
// Purpose: fault supervisor of a switching pre-regulator and two LDOs
// Assumes: comparator flags arrive synchronous to mclk (40 MHz)
// Notes:   registers over Avalon-MM, one wait state on every access
`timescale 1ns/1ps
`include "rfs_regs.svh"

//////////////////////////////////////////////////////////////////////////////
module rfs_supervisor #(
	parameter int OC_LOW_LIMIT  = 15,
	parameter int OC_HIGH_LIMIT = 60
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// Avalon-MM slave
	input  wire logic [`RFS_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// supply and enable
	input  wire logic                   battery_enable_in,
	input  wire logic                   supply_ok_in,
	// pre-regulator comparators
	input  wire logic                   overcurrent_event,
	input  wire logic                   pre_reg_out_low,
	input  wire logic                   err_amp_max,
	input  wire logic                   pre_reg_overvoltage_flag,
	// switch node and diode
	input  wire logic                   switch_node_short,
	input  wire logic                   catch_diode_missing,
	// charge pump
	input  wire logic                   pump_overvoltage,
	input  wire logic                   charge_pump_rail_open,
	input  wire logic                   pump_cap_pin_a_fault,
	input  wire logic                   pump_cap_pin_b_open,
	// rails and frequency pin
	input  wire logic                   low_ldo_rail_uv,
	input  wire logic                   low_ldo_rail_uv_low,
	input  wire logic                   low_ldo_rail_oc,
	input  wire logic                   high_ldo_rail_fault,
	input  wire logic                   freq_set_sync_pin_bad,
	input  wire logic                   freq_set_sync_pin_clk,
	// regulator control
	output logic                        pre_regulator_en,
	output logic                        ldo_en,
	output logic                        switch_node_gate,
	output logic                        default_osc_clk,
	output logic                        master_fault_reset,
	output logic                        power_on_reset_out,
	output logic                        pump_undervoltage_flag,
	output logic                        irq
);

	//////////////////////////////////////////////////////////////////////
	// local constants
	localparam logic [`RFS_DIV_W-1:0] DIV_HALF =
		`RFS_DIV_W'(`RFS_CLK_HZ / (2 * `RFS_DEF_OSC_HZ));
	localparam logic [`RFS_CNT_W-1:0] LIM_LOW  =
		`RFS_CNT_W'(OC_LOW_LIMIT);
	localparam logic [`RFS_CNT_W-1:0] LIM_HIGH =
		`RFS_CNT_W'(OC_HIGH_LIMIT);

	rfs_pkg::rfs_state_e state_ff;
	rfs_pkg::rfs_state_e nxt_state;

	logic [`RFS_CNT_W-1:0]        oc_cnt_ff;
	logic [`RFS_HICCUP_CYC_W-1:0] hiccup_cnt_ff;
	logic [`RFS_DIV_W-1:0]        div_ff;
	logic                         osc_ff;
	logic                         osc_prev_ff;
	logic                         cyc_oc_ff;
	logic                         latch_ff;
	logic                         hard_latch_ff;
	logic                         enable_prev_ff;
	logic                         supply_prev_ff;
	logic                         waitreq_ff;
	logic [31:0]                  rdata_ff;
	logic [`RFS_CTRL_W-1:0]       ctrl_ff;
	logic [`RFS_EVT_W-1:0]        irq_en_ff;
	logic                         lowuv_prev_ff;
	logic                         pump_prev_ff;

	logic                         cycle_end;
	logic                         osc_rise;
	logic                         sel_clk;
	logic                         oc_counted;
	logic [`RFS_CNT_W-1:0]        oc_limit;
	logic                         hiccup_hit;
	logic                         latch_set;
	logic                         latch_clr;
	logic                         pump_uv;
	logic                         nonlatch_fault;
	logic                         low_rail_bad;
	logic                         run_ok;
	logic [`RFS_EVT_W-1:0]        evt;
	logic [`RFS_EVT_W-1:0]        status;
	logic                         bus_go;
	logic                         clr_we;

	//////////////////////////////////////////////////////////////////////
	// oscillator: default 900 kHz unless the pin gives a clock
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_ff <= `RFS_DIV_ZERO;
			osc_ff <= 1'b0;
		end
		else if (div_ff == DIV_HALF - `RFS_DIV_ONE)
		begin
			div_ff <= `RFS_DIV_ZERO;
			osc_ff <= ~osc_ff;
		end
		else
			div_ff <= div_ff + `RFS_DIV_ONE;
	end

	// pin clock used only when the pin is healthy
	assign sel_clk = freq_set_sync_pin_bad ? osc_ff
		: freq_set_sync_pin_clk;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			osc_prev_ff <= 1'b0;
		else
			osc_prev_ff <= sel_clk;
	end

	assign osc_rise        = sel_clk & ~osc_prev_ff;
	assign cycle_end       = osc_rise;
	assign default_osc_clk = osc_ff;

	//////////////////////////////////////////////////////////////////////
	// overcurrent in this switching cycle; on-pulse ends at the limit
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			cyc_oc_ff <= 1'b0;
		else if (cycle_end)
			cyc_oc_ff <= 1'b0;
		else if (overcurrent_event)
			cyc_oc_ff <= 1'b1;
	end

	assign switch_node_gate = pre_regulator_en & ~cyc_oc_ff
		& ~overcurrent_event & ~osc_rise;

	//////////////////////////////////////////////////////////////////////
	// counted events only with the error amplifier at its maximum
	assign oc_counted = cycle_end & cyc_oc_ff & err_amp_max;
	assign oc_limit   = pre_reg_out_low ? LIM_LOW : LIM_HIGH;
	assign hiccup_hit = oc_counted
		&& (oc_cnt_ff + `RFS_CNT_ONE >= oc_limit);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			oc_cnt_ff <= `RFS_CNT_ZERO;
		else if (hiccup_hit || (cycle_end && !cyc_oc_ff))
			oc_cnt_ff <= `RFS_CNT_ZERO;
		else if (oc_counted)
			oc_cnt_ff <= oc_cnt_ff + `RFS_CNT_ONE;
	end

	//////////////////////////////////////////////////////////////////////
	// latched faults and the edges that clear them
	assign latch_set = catch_diode_missing
		| switch_node_short
		| pre_reg_overvoltage_flag;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			enable_prev_ff <= 1'b0;
			supply_prev_ff <= 1'b0;
		end
		else
		begin
			enable_prev_ff <= battery_enable_in;
			supply_prev_ff <= supply_ok_in;
		end
	end

	assign latch_clr = (enable_prev_ff & ~battery_enable_in)
		| (supply_prev_ff & ~supply_ok_in);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			latch_ff <= 1'b0;
		else if (latch_set)
			latch_ff <= 1'b1;
		else if (latch_clr)
			latch_ff <= 1'b0;
	end

	// only diode and switch-node latches hold the reset output low
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			hard_latch_ff <= 1'b0;
		else if (catch_diode_missing | switch_node_short)
			hard_latch_ff <= 1'b1;
		else if (latch_clr)
			hard_latch_ff <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////
	// non-latched master faults
	assign pump_uv = charge_pump_rail_open | pump_cap_pin_a_fault
		| pump_cap_pin_b_open;
	assign pump_undervoltage_flag = pump_uv;
	assign nonlatch_fault = pump_uv | pump_overvoltage;

	assign master_fault_reset = latch_ff | latch_set
		| nonlatch_fault;

	//////////////////////////////////////////////////////////////////////
	// hiccup and run state
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			rfs_pkg::RFS_RUN:
			begin
				if (latch_set)
					nxt_state = rfs_pkg::RFS_LATCHED;
				else if (hiccup_hit)
					nxt_state = rfs_pkg::RFS_HICCUP;
			end
			rfs_pkg::RFS_HICCUP:
			begin
				if (latch_set)
					nxt_state = rfs_pkg::RFS_LATCHED;
				else if (cycle_end && hiccup_cnt_ff == `RFS_HCC_ZERO)
					nxt_state = rfs_pkg::RFS_RUN;
			end
			rfs_pkg::RFS_LATCHED:
			begin
				if (!latch_set && latch_clr)
					nxt_state = rfs_pkg::RFS_RUN;
			end
			default:
				nxt_state = rfs_pkg::RFS_RUN;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			state_ff <= rfs_pkg::RFS_RUN;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			hiccup_cnt_ff <= `RFS_HCC_ZERO;
		else if (hiccup_hit)
			hiccup_cnt_ff <= `RFS_HICCUP_CYC;
		else if (cycle_end && hiccup_cnt_ff != `RFS_HCC_ZERO)
			hiccup_cnt_ff <= hiccup_cnt_ff - `RFS_HCC_ONE;
	end

	assign run_ok = battery_enable_in & supply_ok_in & ~master_fault_reset
		& (state_ff == rfs_pkg::RFS_RUN);
	assign pre_regulator_en = run_ok;
	assign ldo_en           = run_ok;

	//////////////////////////////////////////////////////////////////////
	// reset output follows the low rail, forced low by hard latches
	assign low_rail_bad = low_ldo_rail_uv
		| (low_ldo_rail_oc & low_ldo_rail_uv_low);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			power_on_reset_out <= 1'b0;
		else
			power_on_reset_out <= ~(low_rail_bad | catch_diode_missing
				| switch_node_short | hard_latch_ff);
	end

	//////////////////////////////////////////////////////////////////////
	// events
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			lowuv_prev_ff <= 1'b0;
			pump_prev_ff  <= 1'b0;
		end
		else
		begin
			lowuv_prev_ff <= low_rail_bad;
			pump_prev_ff  <= nonlatch_fault;
		end
	end

	always_comb
	begin
		evt                    = {`RFS_EVT_W{1'b0}};
		evt[`RFS_EVT_HICCUP]  = hiccup_hit;
		evt[`RFS_EVT_DIODE]   = catch_diode_missing;
		evt[`RFS_EVT_SWSHORT] = switch_node_short;
		evt[`RFS_EVT_PREOV]   = pre_reg_overvoltage_flag;
		evt[`RFS_EVT_PUMP]    = nonlatch_fault & ~pump_prev_ff;
		evt[`RFS_EVT_LOWUV]   = low_rail_bad & ~lowuv_prev_ff;
	end

	assign bus_go = (avs_read | avs_write) & ~waitreq_ff;
	assign clr_we = bus_go & avs_write & avs_byteenable[0]
		& (avs_address == `RFS_OFF_IRQ_CLR);

	rfs_event_sync #(
		.W (`RFS_EVT_W)
	) u_events (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.evt_pulse (evt),
		.clr_bits  (avs_writedata[`RFS_EVT_W-1:0]),
		.clr_we    (clr_we),
		.en_bits   (irq_en_ff),
		.status    (status),
		.irq       (irq)
	);

	//////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: waitrequest high first cycle, low on the second
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			waitreq_ff <= 1'b1;
		else if ((avs_read | avs_write) && waitreq_ff)
			waitreq_ff <= 1'b0;
		else
			waitreq_ff <= 1'b1;
	end

	assign avs_waitrequest = waitreq_ff;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			irq_en_ff <= {`RFS_EVT_W{1'b0}};
			ctrl_ff   <= `RFS_CTRL_RESET;
		end
		else if (bus_go && avs_write && avs_byteenable[0])
		begin
			if (avs_address == `RFS_OFF_IRQ_EN)
				irq_en_ff <= avs_writedata[`RFS_EVT_W-1:0];
			if (avs_address == `RFS_OFF_CTRL)
				ctrl_ff <= avs_writedata[`RFS_CTRL_W-1:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rdata_ff <= `RFS_WORD_ZERO;
		else if (avs_read && waitreq_ff)
		begin
			case (avs_address)
				`RFS_OFF_STATUS:
					rdata_ff <= {{(32-`RFS_EVT_W){1'b0}}, status};
				`RFS_OFF_IRQ_EN:
					rdata_ff <= {{(32-`RFS_EVT_W){1'b0}}, irq_en_ff};
				`RFS_OFF_CTRL:
					rdata_ff <= {{(32-`RFS_CTRL_W-4){1'b0}},
						power_on_reset_out, latch_ff,
						state_ff == rfs_pkg::RFS_HICCUP,
						master_fault_reset, ctrl_ff};
				default:
					rdata_ff <= `RFS_WORD_ZERO;
			endcase
		end
	end

	// read data valid at the edge where waitrequest is low
	assign avs_readdata = rdata_ff;

endmodule : rfs_supervisor

// File: verification/rfs_sva.sv
// Purpose: port assertions of the fault supervisor
// Assumes: one clock, synchronous reset
// Notes:   bound to rfs_supervisor below
`timescale 1ns/1ps

module rfs_sva_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// supply and faults
	input wire logic battery_enable_in,
	input wire logic supply_ok_in,
	input wire logic switch_node_short,
	input wire logic catch_diode_missing,
	input wire logic pump_overvoltage,
	input wire logic charge_pump_rail_open,
	input wire logic pump_cap_pin_a_fault,
	input wire logic pump_cap_pin_b_open,
	input wire logic low_ldo_rail_uv,
	// outputs watched
	input wire logic pre_regulator_en,
	input wire logic ldo_en,
	input wire logic master_fault_reset,
	input wire logic power_on_reset_out,
	input wire logic pump_undervoltage_flag
);
	wire en_on = battery_enable_in && supply_ok_in;
	wire pump_bad = pump_overvoltage || pump_undervoltage_flag;

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_pump_uv_flag: assert property (
		(charge_pump_rail_open || pump_cap_pin_a_fault || pump_cap_pin_b_open)
		|-> pump_undervoltage_flag) else $error("pump flag missing");
	a_pump_master: assert property (
		pump_bad |-> master_fault_reset) else $error("pump fault ignored");
	a_master_off: assert property (
		master_fault_reset |-> !pre_regulator_en && !ldo_en)
		else $error("regulator on in fault");
	a_diode_latch: assert property (
		(catch_diode_missing && en_on) ##1 en_on |-> master_fault_reset)
		else $error("diode fault not latched");
	a_short_latch: assert property (
		(switch_node_short && en_on) ##1 en_on |-> master_fault_reset && !ldo_en)
		else $error("short fault not latched");
	a_latch_hold: assert property (
		(master_fault_reset && !pump_bad && en_on) ##1 en_on
		|-> master_fault_reset) else $error("latched fault dropped");
	a_low_uv_por: assert property (
		low_ldo_rail_uv |=> !power_on_reset_out) else $error("reset not low");
	a_fault_por: assert property (
		(catch_diode_missing && en_on) ##1 en_on |=> !power_on_reset_out)
		else $error("reset high in diode fault");
endmodule : rfs_sva_chk

bind rfs_supervisor rfs_sva_chk u_chk (.mclk, .sys_rst, .battery_enable_in,
	.supply_ok_in, .switch_node_short, .catch_diode_missing, .pump_overvoltage,
	.charge_pump_rail_open, .pump_cap_pin_a_fault, .pump_cap_pin_b_open,
	.low_ldo_rail_uv, .pre_regulator_en, .ldo_en, .master_fault_reset,
	.power_on_reset_out, .pump_undervoltage_flag);

// File: verification/rfs_mcu_model.sv
// Purpose: host controller watching the reset output
// Assumes: reset output is low active
// Notes:   counts the resets it receives
`timescale 1ns/1ps

module rfs_mcu_model (
	// clock
	input  wire logic mclk,
	// reset line
	input  wire logic power_on_reset_out,
	// status
	output logic      mcu_running,
	output int        reset_cnt
);
	always_ff @(posedge mclk)
	begin
		mcu_running <= power_on_reset_out;
		if (mcu_running && !power_on_reset_out)
			reset_cnt <= reset_cnt + 1;
	end
endmodule : rfs_mcu_model

// File: verification/tb.sv
// Purpose: self-checking bench of the fault supervisor
// Assumes: 40 MHz mclk, one wait state per access
// Notes:   switching cycles come from pulsing the sync pin clock
`timescale 1ns/1ps
`include "rfs_regs.svh"
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", nm, e, s); end end

module tb;
	logic        mclk, sys_rst, avs_read, avs_write, mcu_running;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        avs_waitrequest, prev;
	logic battery_enable_in, supply_ok_in, overcurrent_event, pre_reg_out_low;
	logic err_amp_max, pre_reg_overvoltage_flag, switch_node_short;
	logic catch_diode_missing, pump_overvoltage, charge_pump_rail_open;
	logic pump_cap_pin_a_fault, pump_cap_pin_b_open, low_ldo_rail_uv;
	logic low_ldo_rail_uv_low, low_ldo_rail_oc, high_ldo_rail_fault;
	logic freq_set_sync_pin_bad, freq_set_sync_pin_clk, pre_regulator_en;
	logic ldo_en, switch_node_gate, default_osc_clk, master_fault_reset;
	logic power_on_reset_out, pump_undervoltage_flag, irq;
	int   mismatches, tests_run, cyc, n, rc, reset_cnt;
	typedef struct packed { logic [3:0] in; logic [1:0] exp; } rfs_row_s;
	rfs_row_s rows [6] = '{'{4'h0, 2'h0}, '{4'h8, 2'h2}, '{4'h4, 2'h3},
		'{4'h2, 2'h3}, '{4'h1, 2'h3}, '{4'h0, 2'h0}};

	rfs_supervisor DUT (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.battery_enable_in, .supply_ok_in, .overcurrent_event,
		.pre_reg_out_low, .err_amp_max, .pre_reg_overvoltage_flag,
		.switch_node_short, .catch_diode_missing, .pump_overvoltage,
		.charge_pump_rail_open, .pump_cap_pin_a_fault, .pump_cap_pin_b_open,
		.low_ldo_rail_uv, .low_ldo_rail_uv_low, .low_ldo_rail_oc,
		.high_ldo_rail_fault, .freq_set_sync_pin_bad, .freq_set_sync_pin_clk,
		.pre_regulator_en, .ldo_en, .switch_node_gate, .default_osc_clk,
		.master_fault_reset, .power_on_reset_out, .pump_undervoltage_flag,
		.irq);
	rfs_mcu_model u_mcu (.mclk, .power_on_reset_out, .mcu_running,
		.reset_cnt);

	////////////////////////////////////////
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
	endtask : tick
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do
		begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : acc
	// one switching cycle per pin clock pulse, counted at its rising edge
	task automatic sw(input int cnt, input logic oc);
		repeat (cnt)
		begin
			overcurrent_event <= oc;
			tick(2);
			overcurrent_event <= 1'b0;
			freq_set_sync_pin_clk <= 1'b1;
			tick(2);
			freq_set_sync_pin_clk <= 1'b0;
			tick(2);
		end
	endtask : sw
	task automatic waitpor;
		n = 0;
		while (power_on_reset_out !== 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		`CHK("por up", 1'b1, power_on_reset_out)
	endtask : waitpor
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			report_and_stop;
		end
	end

	initial
	begin
		{sys_rst, battery_enable_in, supply_ok_in} = 3'h7;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{overcurrent_event, pre_reg_out_low, err_amp_max} = 3'h0;
		{pre_reg_overvoltage_flag, switch_node_short, catch_diode_missing} = 3'h0;
		{pump_overvoltage, charge_pump_rail_open, pump_cap_pin_a_fault} = 3'h0;
		{pump_cap_pin_b_open, low_ldo_rail_uv, low_ldo_rail_uv_low} = 3'h0;
		{low_ldo_rail_oc, high_ldo_rail_fault} = 2'h0;
		{freq_set_sync_pin_bad, freq_set_sync_pin_clk} = 2'h0;
		tick(20);
		`CHK("por in reset", 1'b0, power_on_reset_out)
		sys_rst <= 1'b0;
		tick(2);
		`CHK("irq idle", 1'b0, irq)
		foreach (rows[i])
		begin
			{pump_overvoltage, charge_pump_rail_open, pump_cap_pin_a_fault,
				pump_cap_pin_b_open} <= rows[i].in;
			tick(2);
			`CHK("master", rows[i].exp[1], master_fault_reset)
			`CHK("pump uv", rows[i].exp[0], pump_undervoltage_flag)
			`CHK("pre en", !rows[i].exp[1], pre_regulator_en)
		end
		$display("done: pump table");
		acc(1'b1, `RFS_OFF_CTRL, 32'h0000_00A5);
		acc(1'b0, `RFS_OFF_CTRL, `RFS_WORD_ZERO);
		`CHK("scratch", 8'hA5, q[7:0])
		acc(1'b0, 4'h2, `RFS_WORD_ZERO);
		`CHK("unmapped", `RFS_WORD_ZERO, q)
		acc(1'b1, `RFS_OFF_IRQ_EN, 32'h0000_0001);
		$display("done: registers");
		waitpor;
		{pre_reg_out_low, err_amp_max} <= 2'h3;
		sw(14, 1'b1);
		sw(1, 1'b0);
		sw(14, 1'b1);
		acc(1'b0, `RFS_OFF_STATUS, `RFS_WORD_ZERO);
		`CHK("no hiccup", 1'b0, q[`RFS_EVT_HICCUP])
		sw(1, 1'b1);
		acc(1'b0, `RFS_OFF_STATUS, `RFS_WORD_ZERO);
		`CHK("hiccup 15", 1'b1, q[`RFS_EVT_HICCUP])
		`CHK("irq set", 1'b1, irq)
		sw(70, 1'b0);
		acc(1'b1, `RFS_OFF_IRQ_EN, `RFS_WORD_ZERO);
		`CHK("irq masked", 1'b0, irq)
		acc(1'b1, `RFS_OFF_IRQ_EN, 32'h0000_0001);
		`CHK("irq unmask", 1'b1, irq)
		acc(1'b1, `RFS_OFF_IRQ_CLR, 32'h0000_0001);
		`CHK("irq clear", 1'b0, irq)
		pre_reg_out_low <= 1'b0;
		sw(59, 1'b1);
		acc(1'b0, `RFS_OFF_STATUS, `RFS_WORD_ZERO);
		`CHK("no hiccup 59", 1'b0, q[`RFS_EVT_HICCUP])
		sw(1, 1'b1);
		acc(1'b0, `RFS_OFF_STATUS, `RFS_WORD_ZERO);
		`CHK("hiccup 60", 1'b1, q[`RFS_EVT_HICCUP])
		sw(70, 1'b0);
		acc(1'b1, `RFS_OFF_IRQ_CLR, 32'h0000_0001);
		{pre_reg_out_low, err_amp_max} <= 2'h2;
		sw(20, 1'b1);
		acc(1'b0, `RFS_OFF_STATUS, `RFS_WORD_ZERO);
		`CHK("limit only", 1'b0, q[`RFS_EVT_HICCUP])
		`CHK("limit resume", 1'b1, switch_node_gate)
		overcurrent_event <= 1'b1;
		tick(1);
		`CHK("limit gate", 1'b0, switch_node_gate)
		`CHK("limit master", 1'b0, master_fault_reset)
		overcurrent_event <= 1'b0;
		$display("done: overcurrent");
		for (int k = 0; k < 3; k++)
		begin
			waitpor;
			catch_diode_missing <= (k == 0);
			switch_node_short <= (k == 1);
			pre_reg_overvoltage_flag <= (k == 2);
			tick(1);
			{catch_diode_missing, switch_node_short} <= 2'h0;
			pre_reg_overvoltage_flag <= 1'b0;
			tick(3);
			`CHK("latch off", 2'h0, {pre_regulator_en, ldo_en})
			`CHK("latch por", k == 2, power_on_reset_out)
			acc(1'b1, `RFS_OFF_IRQ_CLR, 32'h0000_003F);
			tick(5);
			`CHK("still off", 1'b0, pre_regulator_en)
			if (k == 1)
				supply_ok_in <= 1'b0;
			else
				battery_enable_in <= 1'b0;
			tick(2);
			{battery_enable_in, supply_ok_in} <= 2'h3;
			tick(2);
			`CHK("cycled on", 1'b1, pre_regulator_en)
		end
		$display("done: latched faults");
		waitpor;
		rc = reset_cnt;
		low_ldo_rail_uv <= 1'b1;
		tick(3);
		`CHK("uv por", 1'b0, power_on_reset_out)
		`CHK("uv master", 1'b0, master_fault_reset)
		low_ldo_rail_uv <= 1'b0;
		waitpor;
		`CHK("uv free", 1'b1, power_on_reset_out)
		`CHK("mcu resets", rc + 1, reset_cnt)
		{low_ldo_rail_oc, high_ldo_rail_fault} <= 2'h3;
		tick(5);
		`CHK("oc por", 1'b1, power_on_reset_out)
		low_ldo_rail_uv_low <= 1'b1;
		tick(3);
		`CHK("oc low por", 1'b0, power_on_reset_out)
		{low_ldo_rail_oc, high_ldo_rail_fault, low_ldo_rail_uv_low} <= 3'h0;
		waitpor;
		$display("done: low rail");
		freq_set_sync_pin_bad <= 1'b1;
		tick(2);
		n = 0;
		prev = default_osc_clk;
		repeat (440)
		begin
			@(posedge mclk);
			if (default_osc_clk !== prev)
				n++;
			prev = default_osc_clk;
		end
		`CHK("osc toggles", 1'b1, n >= 19 && n <= 21)
		`CHK("osc por", 1'b1, power_on_reset_out)
		sys_rst <= 1'b1;
		tick(2);
		`CHK("por rereset", 1'b0, power_on_reset_out)
		sys_rst <= 1'b0;
		tick(2);
		$display("done: oscillator and reset");
		report_and_stop;
	end
endmodule : tb
